// ==== src/jcp_pkg.sv ====
// Shared constants and types for the test-port configuration loader.
// Assumes the importing modules run a 16-state test access port and a core-side loader.
package jcp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction register
    localparam int             IR_W          = 10;
    localparam logic [IR_W-1:0] IR_BYPASS    = 10'h3ff;
    localparam logic [IR_W-1:0] IR_CFG_LOAD  = 10'h002;
    localparam logic [IR_W-1:0] IR_DONE_READ = 10'h004;
    // Capture pattern keeps the two low bits at 01 as the boundary-scan scheme expects
    localparam logic [IR_W-1:0] IR_CAPTURE   = 10'h001;

    ////////////////////////////////////////////////////////////////////////////
    // Status shifted out by the done-read instruction: {init_done, overflow, cfg_done}
    localparam int STAT_W    = 3;
    localparam int STAT_DONE = 0;
    localparam int STAT_OVF  = 1;
    localparam int STAT_INIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Data path and timing
    localparam int          BYTE_W        = 8;
    localparam int          BIT_CNT_W     = 3;
    localparam logic [2:0]  BIT_LAST      = 3'h7;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          INIT_CNT_W    = 9;
    localparam logic [8:0]  INIT_CYCLES   = 9'h12b; // 299 clocks of initialisation
    localparam int          DIV_W         = 4;
    localparam logic [3:0]  ACT_HALF      = 4'h4;
    localparam logic [3:0]  FAST_HALF     = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Scheme select pin codes
    localparam logic [1:0] SCH_ACT  = 2'h0;
    localparam logic [1:0] SCH_PAS  = 2'h1;
    localparam logic [1:0] SCH_FAST = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // State types
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
    } jcp_tap_t;

    typedef enum logic [1:0] {
        M_IDLE, M_PAS, M_JTAG, M_USER
    } jcp_mode_t;

endpackage

// ==== src/jcp_sync.sv ====
// Two-stage level synchroniser, one bit per lane.
// Assumes inputs are levels that stay put for at least two destination clocks.
`timescale 1ns/1ps
module jcp_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Levels
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } jcp_sync_st_t;

    jcp_sync_st_t s_q, s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d.meta = d_i;
        s_d.stab = s_q.meta;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q_o = s_q.stab;
endmodule

// ==== src/jcp_fifo.sv ====
// Dual-clock FIFO with gray-coded pointers, valid/ready on both sides.
// Assumes DEPTH is a power of two, at least 4; both sides share one async reset.
`timescale 1ns/1ps
module jcp_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    // Reset
    input  wire logic         rstn_i,
    // Fill side
    input  wire logic         wr_clk_i,
    input  wire logic         wr_valid_i,
    output logic              wr_ready_o,
    input  wire logic [W-1:0] wr_data_i,
    // Drain side
    input  wire logic         rd_clk_i,
    output logic              rd_valid_o,
    input  wire logic         rd_ready_i,
    output logic      [W-1:0] rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0]             bin;
        logic [AW:0]             gray;
        logic [AW:0]             rg_meta;
        logic [AW:0]             rg_stab;
    } jcp_fifo_wr_t;

    typedef struct packed {
        logic [AW:0] bin;
        logic [AW:0] gray;
        logic [AW:0] wg_meta;
        logic [AW:0] wg_stab;
    } jcp_fifo_rd_t;

    jcp_fifo_wr_t w_q, w_d;
    jcp_fifo_rd_t r_q, r_d;
    logic         full;
    logic         empty;

    ////////////////////////////////////////////////////////////////////////////
    // Fill side: full is pessimistic, the read pointer it sees is two clocks old
    assign full       = (w_q.gray == {~w_q.rg_stab[AW:AW-1], w_q.rg_stab[AW-2:0]});
    assign wr_ready_o = ~full;

    always_comb begin
        w_d         = w_q;
        w_d.rg_meta = r_q.gray;
        w_d.rg_stab = w_q.rg_meta;
        if (wr_valid_i && !full) begin
            w_d.mem[w_q.bin[AW-1:0]] = wr_data_i;
            w_d.bin                  = w_q.bin + 1'b1;
            w_d.gray                 = bin2gray(w_d.bin);
        end
    end

    always_ff @(posedge wr_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            w_q <= '0;
        end else begin
            w_q <= w_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drain side
    assign empty      = (r_q.gray == r_q.wg_stab);
    assign rd_valid_o = ~empty;
    assign rd_data_o  = w_q.mem[r_q.bin[AW-1:0]];

    always_comb begin
        r_d         = r_q;
        r_d.wg_meta = w_q.gray;
        r_d.wg_stab = r_q.wg_meta;
        if (rd_ready_i && !empty) begin
            r_d.bin  = r_q.bin + 1'b1;
            r_d.gray = bin2gray(r_d.bin);
        end
    end

    always_ff @(posedge rd_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end
endmodule

// ==== src/jcp_loader.sv ====
// Configuration loader reached through the test access port, with a passive serial fallback.
// Assumes tck_i is the test clock from the external controller, tms_i/tdi_i change with
// it, and the configuration memory downstream takes bytes on the core clock.
`timescale 1ns/1ps
module jcp_loader
    import jcp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // Core clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    // Test access port
    input  wire logic              tck_i,
    input  wire logic              tms_i,
    input  wire logic              tdi_i,
    output logic                   tdo_o,
    output logic                   tdo_oe_o,
    // Serial configuration pins
    input  wire logic [1:0]        scheme_select_pins_i,
    input  wire logic              pv_clk_i,
    input  wire logic              pv_data_i,
    output logic                   config_serial_clock_o,
    output logic                   config_serial_clock_oe_o,
    // Configuration memory side
    output logic      [BYTE_W-1:0] cfg_data_o,
    output logic                   cfg_valid_o,
    input  wire logic              cfg_ready_i,
    output logic                   cfg_clear_o,
    input  wire logic              cfg_done_i,
    input  wire logic              decompress_req_i,
    // Device status
    output logic                   decompress_en_o,
    output logic                   io_tristate_o,
    output logic                   user_mode_o
);

    function automatic jcp_tap_t tap_next(input jcp_tap_t s, input logic tms);
        case (s)
            TAP_RESET:  tap_next = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = tms ? TAP_RESET  : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
            default:    tap_next = TAP_RESET;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Test clock domain, rising edge
    typedef struct packed {
        jcp_tap_t              tap;
        logic [IR_W-1:0]       ir_sh;
        logic [IR_W-1:0]       ir;
        logic [STAT_W-1:0]     dr_sh;
        logic                  byp;
        logic [BIT_CNT_W-1:0]  bits;
        logic [BYTE_W-1:0]     byte_sh;
        logic                  push;
        logic [BYTE_W-1:0]     push_data;
        logic                  ovf;
        logic                  jact;
        logic [INIT_CNT_W-1:0] icnt;
        logic                  idone;
    } jcp_tck_t;

    typedef struct packed {
        logic tdo;
        logic oe;
    } jcp_tckn_t;

    jcp_tck_t    t_q, t_d;
    jcp_tckn_t   n_q, n_d;
    logic        done_tck;
    logic        fifo_wr_ready;
    logic        fifo_rd_valid;
    logic        fifo_rd_ready;
    logic [BYTE_W-1:0] fifo_rd_data;

    jcp_sync #(.W(1)) u_done_sync (
        .clk_i  (tck_i),
        .rstn_i (rstn_i),
        .d_i    (cfg_done_i),
        .q_o    (done_tck)
    );

    always_comb begin
        t_d      = t_q;
        t_d.push = 1'b0;
        t_d.tap  = tap_next(t_q.tap, tms_i);
        // No stall is possible on the test clock, so a refused byte is flagged instead
        if (t_q.push && !fifo_wr_ready) begin
            t_d.ovf = 1'b1;
        end
        case (t_q.tap)
            TAP_RESET: begin
                t_d.ir = IR_BYPASS;
            end
            TAP_CAP_IR: begin
                t_d.ir_sh = IR_CAPTURE;
            end
            TAP_SH_IR: begin
                t_d.ir_sh = {tdi_i, t_q.ir_sh[IR_W-1:1]};
            end
            TAP_UPD_IR: begin
                t_d.ir = t_q.ir_sh;
                if (t_q.ir_sh == IR_CFG_LOAD) begin
                    t_d.jact  = 1'b1;
                    t_d.ovf   = 1'b0;
                    t_d.bits  = '0;
                    t_d.icnt  = '0;
                    t_d.idone = 1'b0;
                end
            end
            TAP_CAP_DR: begin
                t_d.byp                = 1'b0;
                t_d.dr_sh              = '0;
                t_d.dr_sh[STAT_DONE]   = done_tck;
                t_d.dr_sh[STAT_OVF]    = t_q.ovf;
                t_d.dr_sh[STAT_INIT]   = t_q.idone;
            end
            TAP_SH_DR: begin
                t_d.byp   = tdi_i;
                t_d.dr_sh = {tdi_i, t_q.dr_sh[STAT_W-1:1]};
                if (t_q.ir == IR_CFG_LOAD) begin
                    t_d.byte_sh = {tdi_i, t_q.byte_sh[BYTE_W-1:1]};
                    t_d.bits    = t_q.bits + 1'b1;
                    if (t_q.bits == BIT_LAST) begin
                        t_d.push      = 1'b1;
                        t_d.push_data = t_d.byte_sh;
                    end
                end
            end
            default: begin
            end
        endcase
        // Initialisation counts test clocks once the memory reports done
        if (t_q.jact && done_tck && !t_q.idone) begin
            t_d.icnt = t_q.icnt + 1'b1;
            if (t_q.icnt == INIT_CYCLES - 1'b1) begin
                t_d.idone = 1'b1;
            end
        end
    end

    always_ff @(posedge tck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            t_q     <= '0;
            t_q.tap <= TAP_RESET;
            t_q.ir  <= IR_BYPASS;
        end else begin
            t_q <= t_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Test clock domain, falling edge: output stage only
    always_comb begin
        n_d.oe = (t_q.tap == TAP_SH_IR) || (t_q.tap == TAP_SH_DR);
        if (t_q.tap == TAP_SH_IR) begin
            n_d.tdo = t_q.ir_sh[0];
        end else if (t_q.ir == IR_DONE_READ) begin
            n_d.tdo = t_q.dr_sh[0];
        end else begin
            n_d.tdo = t_q.byp;
        end
        if (!n_d.oe) begin
            n_d.tdo = 1'b0;
        end
    end

    always_ff @(negedge tck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            n_q <= '0;
        end else begin
            n_q <= n_d;
        end
    end

    assign tdo_o    = n_q.tdo;
    assign tdo_oe_o = n_q.oe;

    ////////////////////////////////////////////////////////////////////////////
    // Crossing of bitstream bytes into the core clock
    jcp_fifo #(.W(BYTE_W), .DEPTH(DEPTH)) u_fifo (
        .rstn_i     (rstn_i),
        .wr_clk_i   (tck_i),
        .wr_valid_i (t_q.push),
        .wr_ready_o (fifo_wr_ready),
        .wr_data_i  (t_q.push_data),
        .rd_clk_i   (core_clk_i),
        .rd_valid_o (fifo_rd_valid),
        .rd_ready_i (fifo_rd_ready),
        .rd_data_o  (fifo_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Core clock domain
    typedef struct packed {
        jcp_mode_t             mode;
        logic [BYTE_W-1:0]     out_data;
        logic                  out_valid;
        logic                  clear;
        logic [BYTE_W-1:0]     pv_byte;
        logic [BIT_CNT_W-1:0]  pv_bits;
        logic                  pv_clk_prev;
        logic                  jact_prev;
        logic [INIT_CNT_W-1:0] icnt;
        logic [DIV_W-1:0]      div;
        logic                  sclk;
        logic                  sclk_oe;
        logic                  decomp;
        logic                  tristate;
        logic                  user;
    } jcp_core_t;

    jcp_core_t   c_q, c_d;
    logic [1:0]  scheme_s;
    logic        pv_clk_s;
    logic        pv_data_s;
    logic        jact_s;
    logic        idone_s;
    logic        pv_rise;
    logic        jrise;
    logic        act_sel;
    logic [DIV_W-1:0] half;

    jcp_sync #(.W(4)) u_pin_sync (
        .clk_i  (core_clk_i),
        .rstn_i (rstn_i),
        .d_i    ({scheme_select_pins_i, pv_clk_i, pv_data_i}),
        .q_o    ({scheme_s, pv_clk_s, pv_data_s})
    );

    jcp_sync #(.W(2)) u_tck_sync (
        .clk_i  (core_clk_i),
        .rstn_i (rstn_i),
        .d_i    ({t_q.jact, t_q.idone}),
        .q_o    ({jact_s, idone_s})
    );

    assign pv_rise       = pv_clk_s & ~c_q.pv_clk_prev;
    assign jrise         = jact_s & ~c_q.jact_prev;
    assign act_sel       = (scheme_s == SCH_ACT) || (scheme_s == SCH_FAST);
    assign half          = (scheme_s == SCH_FAST) ? FAST_HALF : ACT_HALF;
    // Back-pressure from the memory reaches the FIFO, which then fills
    assign fifo_rd_ready = (c_q.mode == M_JTAG) && (!c_q.out_valid || cfg_ready_i);

    always_comb begin
        c_d             = c_q;
        c_d.clear       = 1'b0;
        c_d.pv_clk_prev = pv_clk_s;
        c_d.jact_prev   = jact_s;
        if (c_q.out_valid && cfg_ready_i) begin
            c_d.out_valid = 1'b0;
        end
        if (jrise) begin
            c_d.mode      = M_JTAG;
            c_d.clear     = 1'b1;
            c_d.pv_bits   = '0;
            c_d.pv_byte   = '0;
            c_d.out_valid = 1'b0;
            c_d.icnt      = '0;
        end else begin
            case (c_q.mode)
                M_IDLE, M_PAS: begin
                    if (pv_rise && scheme_s == SCH_PAS && !cfg_done_i) begin
                        c_d.mode    = M_PAS;
                        c_d.pv_byte = {pv_data_s, c_q.pv_byte[BYTE_W-1:1]};
                        c_d.pv_bits = c_q.pv_bits + 1'b1;
                        // Serial scheme has no stall, a byte meeting a busy output is lost
                        if (c_q.pv_bits == BIT_LAST && !c_d.out_valid) begin
                            c_d.out_data  = c_d.pv_byte;
                            c_d.out_valid = 1'b1;
                        end
                    end
                    if (c_q.mode == M_PAS && cfg_done_i && pv_rise) begin
                        c_d.icnt = c_q.icnt + 1'b1;
                        if (c_q.icnt == INIT_CYCLES - 1'b1) begin
                            c_d.mode = M_USER;
                        end
                    end
                end
                M_JTAG: begin
                    if (fifo_rd_ready && fifo_rd_valid) begin
                        c_d.out_data  = fifo_rd_data;
                        c_d.out_valid = 1'b1;
                    end
                    if (cfg_done_i && idone_s) begin
                        c_d.mode = M_USER;
                    end
                end
                M_USER: begin
                end
                default: begin
                    c_d.mode = M_IDLE;
                end
            endcase
        end
        // Active serial clock is silenced once the test port owns the load
        c_d.sclk_oe = act_sel && (c_d.mode != M_JTAG) && (c_d.mode != M_USER);
        if (!c_d.sclk_oe) begin
            c_d.sclk = 1'b0;
            c_d.div  = '0;
        end else if (c_q.div >= half) begin
            c_d.sclk = ~c_q.sclk;
            c_d.div  = '0;
        end else begin
            c_d.div = c_q.div + 1'b1;
        end
        c_d.decomp   = decompress_req_i && (c_d.mode != M_JTAG);
        c_d.tristate = (c_d.mode != M_USER);
        c_d.user     = (c_d.mode == M_USER);
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            c_q          <= '0;
            c_q.mode     <= M_IDLE;
            c_q.tristate <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    assign cfg_data_o               = c_q.out_data;
    assign cfg_valid_o              = c_q.out_valid;
    assign cfg_clear_o              = c_q.clear;
    assign config_serial_clock_o    = c_q.sclk;
    assign config_serial_clock_oe_o = c_q.sclk_oe;
    assign decompress_en_o          = c_q.decomp;
    assign io_tristate_o            = c_q.tristate;
    assign user_mode_o              = c_q.user;
endmodule

// ==== bench/jcp_loader_assertions.sv ====
// Checker: port timing of the test-port loader.
// Assumes it is bound onto jcp_loader and sees only its ports.
`timescale 1ns/1ps
module jcp_loader_assertions
    import jcp_pkg::*;
(
    // Clocks and reset
    input wire logic              core_clk_i,
    input wire logic              rstn_i,
    input wire logic              tck_i,
    // Test port
    input wire logic              tms_i,
    input wire logic              tdo_o,
    input wire logic              tdo_oe_o,
    // Core side
    input wire logic              config_serial_clock_oe_o,
    input wire logic [BYTE_W-1:0] cfg_data_o,
    input wire logic              cfg_valid_o,
    input wire logic              cfg_ready_i,
    input wire logic              cfg_clear_o,
    input wire logic              decompress_en_o,
    input wire logic              io_tristate_o,
    input wire logic              user_mode_o
);
    property p_rel; @(posedge tck_i) disable iff (!rstn_i) !tdo_oe_o |-> !tdo_o; endproperty
    a_rel: assert property (p_rel) else $error("tdo set while released");
    // A high select always leaves or avoids the shift states
    property p_tms; @(posedge tck_i) disable iff (!rstn_i) tms_i |=> !tdo_oe_o; endproperty
    a_tms: assert property (p_tms) else $error("tdo driven after select high");
    property p_clr; @(posedge core_clk_i) disable iff (!rstn_i)
        cfg_clear_o |=> !cfg_clear_o && !cfg_valid_o; endproperty
    a_clr: assert property (p_clr) else $error("takeover left data");
    property p_sck; @(posedge core_clk_i) disable iff (!rstn_i)
        cfg_clear_o |=> !config_serial_clock_oe_o [*8]; endproperty
    a_sck: assert property (p_sck) else $error("serial clock driven");
    property p_dec; @(posedge core_clk_i) disable iff (!rstn_i)
        cfg_clear_o |=> !decompress_en_o [*8]; endproperty
    a_dec: assert property (p_dec) else $error("decompression on");
    property p_tri; @(posedge core_clk_i) disable iff (!rstn_i)
        !user_mode_o |-> io_tristate_o; endproperty
    a_tri: assert property (p_tri) else $error("pins driven before user mode");
    property p_hold; @(posedge core_clk_i) disable iff (!rstn_i) cfg_valid_o && !cfg_ready_i
        && !cfg_clear_o |=> cfg_valid_o && $stable(cfg_data_o); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped while stalled");
    property p_user; @(posedge core_clk_i) disable iff (!rstn_i)
        user_mode_o |=> user_mode_o; endproperty
    a_user: assert property (p_user) else $error("user mode lost");
endmodule

bind jcp_loader jcp_loader_assertions chk_i (
    .core_clk_i               (core_clk_i),
    .rstn_i                   (rstn_i),
    .tck_i                    (tck_i),
    .tms_i                    (tms_i),
    .tdo_o                    (tdo_o),
    .tdo_oe_o                 (tdo_oe_o),
    .config_serial_clock_oe_o (config_serial_clock_oe_o),
    .cfg_data_o               (cfg_data_o),
    .cfg_valid_o              (cfg_valid_o),
    .cfg_ready_i              (cfg_ready_i),
    .cfg_clear_o              (cfg_clear_o),
    .decompress_en_o          (decompress_en_o),
    .io_tristate_o            (io_tristate_o),
    .user_mode_o              (user_mode_o)
);

// ==== bench/jcp_jtag_host.sv ====
// Model of the external test controller driving the test port.
// Assumes the bench calls its tasks; the clock stands low between frames.
`timescale 1ns/1ps
module jcp_jtag_host (
    // Test port
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o,
    input wire logic  tdo_i
);
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // One test clock; tdo read at the rise, as launched by the fall before
    task automatic step(input logic ms, input logic di, output logic dout);
        tms_o = ms;
        tdi_o = di;
        #7.5 tck_o = 1'b1;
        dout = tdo_i;
        #7.5 tck_o = 1'b0;
    endtask
    task automatic tlr;
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
    // Clocks in idle; the device counts these for initialisation
    task automatic idle(input int n);
        logic b;
        repeat (n) step(1'b0, 1'b1, b);
    endtask
    // From idle to idle: one IR or DR scan, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] d,
                        output logic [31:0] q);
        logic b;
        q = '0;
        step(1'b1, 1'b1, b);
        if (ir) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule

// ==== bench/jcp_loader_tb.sv ====
// Self-checking bench for the test-port configuration loader.
// Assumes jcp_jtag_host drives the test port; the bench plays memory and serial pins.
`timescale 1ns/1ps
module jcp_loader_tb import jcp_pkg::*; ;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        tck, tms, tdi, tdo, tdo_oe, sck, sck_oe, valid, clear, dec_en, tri_io, user;
    logic        ready = 1'b0, pv_clk = 1'b0, pv_data = 1'b0, done = 1'b0, dec_req = 1'b1;
    logic        seen_clr = 1'b0;
    logic        sbit;
    logic [1:0]  scheme = SCH_ACT;
    logic [7:0]  data;
    logic [7:0]  rx[$];
    logic [7:0]  tx[$];
    logic [31:0] q;
    int          n_errors = 0;
    int          n_checks = 0;

    always #50 clk = ~clk;
    jcp_loader dut (.core_clk_i(clk), .rstn_i(rstn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .scheme_select_pins_i(scheme), .pv_clk_i(pv_clk),
        .pv_data_i(pv_data), .config_serial_clock_o(sck), .config_serial_clock_oe_o(sck_oe),
        .cfg_data_o(data), .cfg_valid_o(valid), .cfg_ready_i(ready), .cfg_clear_o(clear),
        .cfg_done_i(done), .decompress_req_i(dec_req), .decompress_en_o(dec_en),
        .io_tristate_o(tri_io), .user_mode_o(user));
    jcp_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
    // The clear is a one-cycle pulse, so it is latched here
    always @(posedge clk) begin
        if (valid === 1'b1 && ready === 1'b1) rx.push_back(data);
        if (clear === 1'b1) seen_clr <= 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pv_bit(input logic b);
        pv_data = b;
        tick(4);
        pv_clk = 1'b1;
        tick(4);
        pv_clk = 1'b0;
    endtask
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic t_bypass;
        scheme = SCH_FAST;
        tick(4);
        sbit = sck;
        tick(2);
        chk({sck_oe, sck}, {1'b1, ~sbit});
        scheme = SCH_ACT;
        tick(4);
        sbit = sck;
        tick(5);
        chk({sck_oe, sck}, {1'b1, ~sbit});
        host.tlr();
        host.scan(1'b0, 8, 32'ha5, q);
        chk(q[7:0], 8'h4a);
        host.scan(1'b1, IR_W, IR_BYPASS, q);
        chk(q[9:0], IR_CAPTURE);
        chk(tdo_oe, 1'b0);
        $display("t_bypass done");
    endtask
    task automatic t_takeover;
        tick(1);
        scheme = SCH_PAS;
        repeat (3) pv_bit(1'b1);
        chk(dec_en, 1'b1);
        host.scan(1'b1, IR_W, IR_CFG_LOAD, q);
        tick(6);
        chk({seen_clr, dec_en, sck_oe}, 3'h4);
        for (int s = 0; s < 3; s++) begin
            scheme = s[1:0];
            tick(4);
            chk(sck_oe, 1'b0);
        end
        scheme = SCH_PAS;
        repeat (8) pv_bit(1'b0);
        chk(rx.size(), 0);
        $display("t_takeover done");
    endtask
    // Memory stalls while 20 bytes arrive, more than the buffer holds
    task automatic t_stream;
        for (int w = 0; w < 5; w++) begin
            for (int k = 0; k < 4; k++) tx.push_back(8'((w * 4 + k) * 29 + 3));
            host.scan(1'b0, 32, {tx[4*w+3], tx[4*w+2], tx[4*w+1], tx[4*w]}, q);
        end
        tick(8);
        ready = 1'b1;
        tick(40);
        for (int i = 0; i < 16; i++) chk(rx[i], tx[i]);
        chk(valid, 1'b0);
        $display("t_stream done");
    endtask
    task automatic t_init;
        done = 1'b1;
        tick(4);
        host.idle(290);
        tick(10);
        chk(user, 1'b0);
        host.idle(20);
        tick(10);
        chk({user, tri_io}, 2'h2);
        host.scan(1'b1, IR_W, IR_DONE_READ, q);
        host.scan(1'b0, STAT_W, 32'h0, q);
        chk(q[2:0], 3'h7);
        $display("t_init done");
    endtask

    initial begin
        tick(7);
        chk({tdo_oe, tri_io, user, valid}, 4'h4);
        tick(1);
        rstn = 1'b1;
        tick(2);
        t_bypass();
        t_takeover();
        t_stream();
        t_init();
        results();
    end
    // Tests need well under 200 us; 1 ms means a hang
    initial begin
        #1_000_000;
        n_errors++;
        results();
    end
endmodule
